// *** rtl/ejector_ctrl.sv ***
`timescale 1ns/1ps

// Operation
// RULE1 - Three blow-off modes; internal timed mode refused in pulse variant.
// RULE2 - Pulse variant ignores suction still held after blow-off; needs a new pulse.
// RULE3 - Starts in direct-wire mode; fieldbus master may switch mode any time.
// RULE4 - After reset the block runs in automatic mode.
// RULE5 - Up and down held over 3 s enter manual mode; limit LEDs flash.
// RULE6 - Manual: up press starts suction, next up or down press ends it.
// RULE7 - Manual: blow-off while down held, both limit LEDs steady on.
// RULE8 - Regulation also governs manual suction when enabled.
// RULE9 - Menu press or any external input change leaves manual mode.
// RULE10 - Setup mode follows process byte bit 2, fieldbus only, LEDs flash.
// RULE11 - Change of process byte bit 0 or 1 leaves setup mode.
// RULE12 - Setup mode disables valve protection, keeps regulating.
// RULE13 - Regulation stops at control limit, resumes below limit minus hysteresis.
// RULE14 - Regulation off gives continuous suction; only if shutoff disable off.
// RULE15 - Too fast valve switching abandons regulation for continuous suction.
// RULE16 - Leakage over limit more than twice in a row abandons regulation.
// RULE17 - Shutoff disabled keeps regulating; enabled falls back above 6 per 3 s.
// RULE18 - Shutoff disable accepted only with a regulating mode selected.
// RULE19 - Undervoltage on normally-open variant gives continuous suction.
// RULE20 - External blow-off lasts as long as input; beats suction.
// RULE21 - Internal timed: suction off starts timed blow; input also triggers.
// RULE22 - External timed: input starts fixed-length blow; holding does not extend.
// RULE23 - Blow duration 0.10 to 9.99 s; hidden in external blow mode.
// RULE24 - Normally-closed sucks on asserted input, normally-open on deasserted; only the direct wire is inverted, process byte bit 0 sucks when set.
// RULE25 - Blow timer counts 10 ms steps from a 1 ms tick, 10 to 999.
module ejector_ctrl
  import ejector_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire pin_t pins_async,
  input wire logic fb_mode_set,
  input wire logic fb_mode_clr,
  input wire logic [7:0] output_process_byte,
  input wire logic opb_valid,
  input wire logic [7:0] vacuum_level,
  input wire logic [7:0] leak_rate,
  input wire logic leak_valid,
  output logic vacuum_gen,
  output logic blow_valve,
  output logic led_limit1,
  output logic led_limit2,
  output logic [1:0] op_mode,
  output logic direct_wire_mode
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    cfg_t cfg;
    mode_t mode;
    logic fbus;
    logic [7:0] opb;
    pin_t s1;
    pin_t s2;
    pin_t s3;
    pin_t filt;
    pin_t fprev;
    logic [17:0] ms_div;
    logic [11:0] hold;
    logic [11:0] win;
    logic [7:0] blk_cnt;
    logic blink;
    logic man_suck;
    logic pulse_suck;
    logic suck_prev;
    logic blow_prev;
    logic [3:0] step;
    logic [9:0] left;
    logic reg_gen;
    logic lim_flag;
    logic fallback;
    logic [3:0] sw_cnt;
    logic [1:0] leak_cnt;
    logic ack;
    logic [31:0] rdata;
    logic gen;
    logic blow;
    logic led1;
    logic led2;
  } st_t;

  st_t q;
  st_t n;

  function automatic logic [31:0] rd_reg(input logic [3:0] a, input st_t s);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      OFS_CTRL: begin
        r = (32'(s.cfg.variant) << CTRL_VAR) | (32'(s.cfg.blow) << CTRL_BLOW)
          | (32'(s.cfg.regm) << CTRL_REG) | (32'(s.cfg.sdis) << CTRL_SDIS);
      end
      OFS_DUR: begin
        if (s.cfg.blow != BM_EXT) begin
          r = 32'(s.cfg.dur); // RULE23
        end
      end
      OFS_LIM: begin
        r = (32'(s.cfg.cl) << LIM_CL) | (32'(s.cfg.hy) << LIM_HY)
          | (32'(s.cfg.lk) << LIM_LK) | (32'(s.cfg.pp) << LIM_PP);
      end
      OFS_STAT: begin
        r = {8'h00, vacuum_level, 6'h00, s.fallback, s.lim_flag,
             s.led2, s.led1, s.blow, s.gen, s.fbus, s.man_suck, s.mode};
      end
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w, input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = w[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Guard against a hysteresis larger than the limit wrapping below zero
  function automatic logic below_hyst(input logic [7:0] v, input logic [7:0] cl, input logic [7:0] hy);
    return (hy <= cl) && (v < cl - hy);
  endfunction

  logic tick;
  logic suck_raw;
  logic blow_raw;
  logic suck_rise;
  logic blow_rise;
  logic menu_rise;
  logic ext_chg;
  logic hold_done;
  logic blow_now;
  logic demand;
  logic reg_on;
  logic monitor;
  logic lim_hi;
  logic sw_evt;
  logic [31:0] w;

  assign avs_waitrequest = (avs_read | avs_write) & ~q.ack;
  assign avs_readdata = q.rdata;
  assign vacuum_gen = q.gen;
  assign blow_valve = q.blow;
  assign led_limit1 = q.led1;
  assign led_limit2 = q.led2;
  assign op_mode = q.mode;
  assign direct_wire_mode = ~q.fbus;

  always_comb begin
    n = q;
    w = 32'h0000_0000;

    // ****************************************
    // Input capture and timebase
    // ****************************************
    n.s1 = pins_async;
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.filt = (q.s2 & q.s3) | (q.filt & (q.s2 ^ q.s3));
    n.fprev = q.filt;
    tick = (q.ms_div == 18'(MS_CYC - 1));
    n.ms_div = tick ? 18'h00000 : q.ms_div + 18'h00001;
    if (tick) begin
      n.blk_cnt = (q.blk_cnt == 8'(BLINK_MS - 1)) ? 8'h00 : q.blk_cnt + 8'h01;
      n.blink = (q.blk_cnt == 8'(BLINK_MS - 1)) ? ~q.blink : q.blink;
    end

    // Fieldbus master owns the mode switch at any moment
    if (fb_mode_set) begin
      n.fbus = 1'b1; // RULE3
    end else if (fb_mode_clr) begin
      n.fbus = 1'b0; // RULE3
    end
    if (q.fbus && opb_valid) begin
      n.opb = output_process_byte;
    end

    // Normally-open sucks while the wire is low
    suck_raw = q.fbus ? q.opb[0] : (q.filt.suction ^ (q.cfg.variant == VAR_NO)); // RULE24
    blow_raw = q.fbus ? q.opb[1] : q.filt.blow;
    n.suck_prev = suck_raw;
    n.blow_prev = blow_raw;
    suck_rise = suck_raw & ~q.suck_prev;
    blow_rise = blow_raw & ~q.blow_prev;
    menu_rise = q.filt.menu & ~q.fprev.menu;
    ext_chg = (q.filt.suction != q.fprev.suction) | (q.filt.blow != q.fprev.blow)
            | (q.fbus & opb_valid & (output_process_byte[1:0] != q.opb[1:0]));

    // ****************************************
    // Operating mode
    // ****************************************
    if (q.filt.up && q.filt.down) begin
      n.hold = (tick && q.hold != 12'(HOLD_MS)) ? q.hold + 12'h001 : q.hold;
    end else begin
      n.hold = 12'h000;
    end
    hold_done = q.filt.up && q.filt.down && tick && q.hold == 12'(HOLD_MS);

    case (q.mode)
      MODE_AUTO: begin
        if (hold_done) begin
          n.mode = MODE_MANUAL; // RULE5
          n.man_suck = 1'b0;
        end else if (q.fbus && opb_valid && output_process_byte[2] && !q.opb[2]) begin
          n.mode = MODE_SETUP; // RULE10
        end
      end
      MODE_MANUAL: begin
        if (menu_rise || ext_chg) begin
          n.mode = MODE_AUTO; // RULE9
          n.man_suck = 1'b0;
        end else if (q.man_suck && ((q.filt.up && !q.fprev.up) || (q.filt.down && !q.fprev.down))) begin
          n.man_suck = 1'b0; // RULE6
        end else if (q.filt.up && !q.fprev.up) begin
          n.man_suck = 1'b1; // RULE6
        end
      end
      MODE_SETUP: begin
        if (!q.fbus || (opb_valid && !output_process_byte[2])) begin
          n.mode = MODE_AUTO; // RULE10
        end else if (opb_valid && output_process_byte[1:0] != q.opb[1:0]) begin
          n.mode = MODE_AUTO; // RULE11
        end
      end
      default: n.mode = MODE_AUTO;
    endcase

    // ****************************************
    // Blow-off timing
    // ****************************************
    if (q.mode != MODE_MANUAL && q.cfg.blow != BM_EXT
        && ((q.cfg.blow == BM_INT && !suck_raw && q.suck_prev) || blow_rise)) begin
      n.left = q.cfg.dur; // RULE21 RULE22
      n.step = 4'h0;
    end else if (tick && q.left != 10'h000) begin
      n.step = (q.step == 4'(STEPS - 1)) ? 4'h0 : q.step + 4'h1; // RULE25
      n.left = (q.step == 4'(STEPS - 1)) ? q.left - 10'h001 : q.left; // RULE25
    end

    if (q.mode == MODE_MANUAL) begin
      blow_now = q.filt.down; // RULE7
    end else if (q.cfg.blow == BM_EXT) begin
      blow_now = blow_raw; // RULE20
    end else begin
      blow_now = q.left != 10'h000; // RULE21 RULE22
    end

    // A held suction line after blow-off stays ignored until it pulses again
    if (blow_now) begin
      n.pulse_suck = 1'b0; // RULE2
    end else if (suck_rise) begin
      n.pulse_suck = 1'b1; // RULE2
    end

    if (q.mode == MODE_MANUAL) begin
      demand = q.man_suck & ~blow_now; // RULE8
    end else if (q.cfg.variant == VAR_PULSE) begin
      demand = q.pulse_suck & ~blow_now; // RULE2
    end else begin
      demand = suck_raw & ~blow_now; // RULE20
    end

    // ****************************************
    // Regulation and protection
    // ****************************************
    reg_on = q.cfg.regm != RM_OFF;
    lim_hi = vacuum_level >= q.cfg.cl;
    if (lim_hi) begin
      n.lim_flag = 1'b1; // RULE14
    end else if (below_hyst(vacuum_level, q.cfg.cl, q.cfg.hy)) begin
      n.lim_flag = 1'b0; // RULE14
    end
    if (!demand) begin
      n.reg_gen = 1'b1;
    end else if (lim_hi) begin
      n.reg_gen = 1'b0; // RULE13
    end else if (below_hyst(vacuum_level, q.cfg.cl, q.cfg.hy)) begin
      n.reg_gen = 1'b1; // RULE13
    end

    sw_evt = demand && reg_on && n.reg_gen != q.reg_gen;
    if (tick && q.win == 12'(WIN_MS - 1)) begin
      n.win = 12'h000;
      n.sw_cnt = sw_evt ? 4'h1 : 4'h0; // RULE15
    end else begin
      n.win = tick ? q.win + 12'h001 : q.win;
      if (sw_evt && q.sw_cnt != 4'hf) begin
        n.sw_cnt = q.sw_cnt + 4'h1; // RULE15
      end
    end
    if (leak_valid && q.cfg.regm == RM_LEAK) begin
      n.leak_cnt = (leak_rate <= q.cfg.lk) ? 2'h0 : (q.leak_cnt == 2'h3) ? 2'h3 : q.leak_cnt + 2'h1; // RULE16
    end

    // Protection off in setup and when shutoff is disabled; the valve may wear out then
    monitor = reg_on && !q.cfg.sdis && q.mode != MODE_SETUP; // RULE12 RULE17
    if (!demand) begin
      n.fallback = 1'b0;
    end else if (monitor && (q.sw_cnt > 4'(SW_MAX) || q.leak_cnt > 2'(LEAK_MAX))) begin
      n.fallback = 1'b1; // RULE15 RULE16 RULE17
    end

    n.gen = demand & (!reg_on | n.fallback | n.reg_gen); // RULE13 RULE14
    n.blow = blow_now;
    if (q.filt.undervolt) begin
      n.gen = q.cfg.variant == VAR_NO; // RULE19
      n.blow = 1'b0;
    end

    if (q.mode == MODE_MANUAL && q.filt.down) begin
      n.led1 = 1'b1; // RULE7
      n.led2 = 1'b1; // RULE7
    end else if (q.mode != MODE_AUTO) begin
      n.led1 = q.blink; // RULE5 RULE10
      n.led2 = q.blink; // RULE5 RULE10
    end else begin
      n.led1 = n.lim_flag;
      n.led2 = vacuum_level >= q.cfg.pp;
    end

    // ****************************************
    // Avalon slave, one wait state
    // ****************************************
    n.ack = (avs_read | avs_write) & ~q.ack;
    if (avs_read && !q.ack) begin
      n.rdata = rd_reg(avs_address, q);
    end
    if (avs_write && q.ack) begin
      w = merge(rd_reg(avs_address, q), avs_writedata, avs_byteenable);
      case (avs_address)
        OFS_CTRL: begin
          if (w[CTRL_VAR +: 2] != 2'h3) begin
            n.cfg.variant = variant_t'(w[CTRL_VAR +: 2]);
          end
          if (w[CTRL_BLOW +: 2] != 2'h3
              && !(n.cfg.variant == VAR_PULSE && w[CTRL_BLOW +: 2] == BM_INT)) begin
            n.cfg.blow = blow_mode_t'(w[CTRL_BLOW +: 2]); // RULE1
          end
          if (n.cfg.variant == VAR_PULSE && n.cfg.blow == BM_INT) begin
            n.cfg.blow = BM_EXT; // RULE1
          end
          if (w[CTRL_REG +: 2] != 2'h3 && !(w[CTRL_REG +: 2] == RM_OFF && q.cfg.sdis)) begin
            n.cfg.regm = reg_mode_t'(w[CTRL_REG +: 2]); // RULE14
          end
          if (!w[CTRL_SDIS] || n.cfg.regm != RM_OFF) begin
            n.cfg.sdis = w[CTRL_SDIS]; // RULE18
          end
        end
        OFS_DUR: begin
          if (q.cfg.blow != BM_EXT) begin
            n.cfg.dur = (w[9:0] < DUR_MIN) ? DUR_MIN : (w[9:0] > DUR_MAX) ? DUR_MAX : w[9:0]; // RULE23
          end
        end
        OFS_LIM: begin
          n.cfg.cl = w[LIM_CL +: 8];
          n.cfg.hy = w[LIM_HY +: 8];
          n.cfg.lk = w[LIM_LK +: 8];
          n.cfg.pp = w[LIM_PP +: 8];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.cfg <= CFG_RST;
      q.mode <= MODE_AUTO; // RULE4
      q.reg_gen <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_ext_blow; // RULE20
    q.mode == MODE_AUTO && q.cfg.blow == BM_EXT && blow_raw && !q.filt.undervolt |=> q.blow;
  endproperty
  a_ext_blow: assert property (p_ext_blow) else $error("external blow-off not applied"); // RULE20

  property p_timed_len; // RULE22
    q.mode == MODE_AUTO && q.cfg.blow == BM_ETIM && blow_rise |=> q.left == $past(q.cfg.dur);
  endproperty
  a_timed_len: assert property (p_timed_len) else $error("timed blow-off length wrong"); // RULE22

  property p_timed_blow; // RULE21
    q.mode == MODE_AUTO && q.cfg.blow != BM_EXT && q.left != 10'h000 && !q.filt.undervolt |=> q.blow;
  endproperty
  a_timed_blow: assert property (p_timed_blow) else $error("timed blow-off not held"); // RULE21

  property p_pulse; // RULE2
    q.cfg.variant == VAR_PULSE && blow_now |=> !q.pulse_suck;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse suction kept through blow-off"); // RULE2

  property p_reg_stop; // RULE13
    demand && reg_on && !q.fallback && lim_hi && !q.filt.undervolt |=> !q.gen || q.fallback;
  endproperty
  a_reg_stop: assert property (p_reg_stop) else $error("generation not stopped at limit"); // RULE13

  property p_fb_shutoff; // RULE17
    $rose(q.fallback) |-> !$past(q.cfg.sdis) && $past(q.mode) != MODE_SETUP;
  endproperty
  a_fb_shutoff: assert property (p_fb_shutoff) else $error("fallback while protection off"); // RULE17

  property p_fb_cause; // RULE15
    $rose(q.fallback) |-> $past(q.sw_cnt) > 4'(SW_MAX) || $past(q.leak_cnt) > 2'(LEAK_MAX);
  endproperty
  a_fb_cause: assert property (p_fb_cause) else $error("fallback without cause"); // RULE15

  property p_man_enter; // RULE5
    q.mode == MODE_AUTO && hold_done |=> q.mode == MODE_MANUAL;
  endproperty
  a_man_enter: assert property (p_man_enter) else $error("manual mode not entered"); // RULE5

  property p_man_exit; // RULE9
    q.mode == MODE_MANUAL && (menu_rise || ext_chg) |=> q.mode == MODE_AUTO;
  endproperty
  a_man_exit: assert property (p_man_exit) else $error("manual mode not left"); // RULE9

  property p_man_blow; // RULE7
    q.mode == MODE_MANUAL && q.filt.down && !menu_rise && !ext_chg && !q.filt.undervolt
      |=> q.blow && q.led1 && q.led2;
  endproperty
  a_man_blow: assert property (p_man_blow) else $error("manual blow-off or LEDs wrong"); // RULE7

  property p_setup_exit; // RULE11
    q.mode == MODE_SETUP && opb_valid && output_process_byte[1:0] != q.opb[1:0] |=> q.mode == MODE_AUTO;
  endproperty
  a_setup_exit: assert property (p_setup_exit) else $error("setup mode not left"); // RULE11

  property p_uv; // RULE19
    q.filt.undervolt && q.cfg.variant == VAR_NO |=> q.gen && !q.blow;
  endproperty
  a_uv: assert property (p_uv) else $error("no suction on undervoltage"); // RULE19

  property p_dur; // RULE23
    q.cfg.dur >= DUR_MIN && q.cfg.dur <= DUR_MAX;
  endproperty
  a_dur: assert property (p_dur) else $error("blow duration out of range"); // RULE23

endmodule

// *** include/ejector_pkg.sv ***
package ejector_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 200_000_000;
  localparam int TICK_MS = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int HOLD_S = 3;
  localparam int HOLD_MS = HOLD_S * 1000 / TICK_MS;
  localparam int WIN_S = 3;
  localparam int WIN_MS = WIN_S * 1000 / TICK_MS;
  localparam int STEP_MS = 10;
  localparam int STEPS = STEP_MS / TICK_MS;
  localparam int BLINK_MS = 250;
  localparam int SW_MAX = 6;
  localparam int LEAK_MAX = 2;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_DUR = 4'h4;
  localparam logic [3:0] OFS_LIM = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hc;
  localparam int CTRL_VAR = 0;
  localparam int CTRL_BLOW = 2;
  localparam int CTRL_REG = 4;
  localparam int CTRL_SDIS = 6;
  localparam int LIM_CL = 0;
  localparam int LIM_HY = 8;
  localparam int LIM_LK = 16;
  localparam int LIM_PP = 24;
  localparam int STAT_VAC = 16;
  localparam logic [9:0] DUR_MIN = 10'h00a;
  localparam logic [9:0] DUR_MAX = 10'h3e7;
  localparam logic [9:0] RST_DUR = 10'h014;
  localparam logic [7:0] RST_CL = 8'h96;
  localparam logic [7:0] RST_HY = 8'h0a;
  localparam logic [7:0] RST_LK = 8'h20;
  localparam logic [7:0] RST_PP = 8'h64;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {VAR_NC, VAR_NO, VAR_PULSE} variant_t;
  typedef enum logic [1:0] {BM_EXT, BM_INT, BM_ETIM} blow_mode_t;
  typedef enum logic [1:0] {RM_OFF, RM_ON, RM_LEAK} reg_mode_t;
  typedef enum logic [1:0] {MODE_AUTO, MODE_MANUAL, MODE_SETUP} mode_t;

  typedef struct packed {
    variant_t variant;
    blow_mode_t blow;
    reg_mode_t regm;
    logic sdis;
    logic [9:0] dur;
    logic [7:0] cl;
    logic [7:0] hy;
    logic [7:0] lk;
    logic [7:0] pp;
  } cfg_t;

  typedef struct packed {
    logic suction;
    logic blow;
    logic up;
    logic down;
    logic menu;
    logic undervolt;
  } pin_t;

  localparam cfg_t CFG_RST = '{variant: VAR_NC, blow: BM_EXT, regm: RM_ON, sdis: 1'b0,
                               dur: RST_DUR, cl: RST_CL, hy: RST_HY, lk: RST_LK, pp: RST_PP};

endpackage

// *** verification/ejector_host_model.sv ***
`timescale 1ns/1ps

// ****************************************
// Controller side: discrete pins and cyclic process data
// ****************************************
module ejector_host_model
  import ejector_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire pin_t want_pins,
  input wire logic want_fb,
  input wire logic [7:0] want_opb,
  output pin_t pins_async,
  output logic fb_mode_set,
  output logic fb_mode_clr,
  output logic [7:0] output_process_byte,
  output logic opb_valid
);
  logic fb_q;
  logic [2:0] slot_q;

  // Byte is scrambled between valid slots so a stale value is never trusted
  assign output_process_byte = opb_valid ? want_opb : ~want_opb;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pins_async <= '0;
      fb_q <= 1'b0;
      fb_mode_set <= 1'b0;
      fb_mode_clr <= 1'b0;
      slot_q <= 3'h0;
      opb_valid <= 1'b0;
    end else begin
      pins_async <= want_pins;
      fb_mode_set <= want_fb & ~fb_q;
      fb_mode_clr <= ~want_fb & fb_q;
      fb_q <= want_fb;
      slot_q <= slot_q + 3'h1;
      opb_valid <= (slot_q == 3'h0);
    end
  end
endmodule

// *** verification/ejector_suction_blowoff_control_bench.sv ***
`timescale 1ns/1ps

// ****************************************
// Bench: bus access, pins, process data and timing checks
// ****************************************
module ejector_suction_blowoff_control_bench;
  import ejector_pkg::*;
  // Short millisecond keeps the 3 s hold inside the run
  localparam int MS = 4;
  logic sys_clk, reset, avs_read, avs_write, avs_waitrequest, fb_mode_set, fb_mode_clr, opb_valid, leak_valid;
  logic vacuum_gen, blow_valve, led_limit1, led_limit2, direct_wire_mode, want_fb;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [7:0] output_process_byte, vacuum_level, leak_rate, want_opb;
  logic [1:0] op_mode;
  logic [15:0] seed;
  pin_t pins_async, want_pins;
  int n_errors, compares, cyc, n, i;

  ejector_ctrl #(.MS_CYC(MS)) ejector_ctrl_i (.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pins_async(pins_async),
    .fb_mode_set(fb_mode_set), .fb_mode_clr(fb_mode_clr), .output_process_byte(output_process_byte),
    .opb_valid(opb_valid), .vacuum_level(vacuum_level), .leak_rate(leak_rate), .leak_valid(leak_valid),
    .vacuum_gen(vacuum_gen), .blow_valve(blow_valve), .led_limit1(led_limit1), .led_limit2(led_limit2),
    .op_mode(op_mode), .direct_wire_mode(direct_wire_mode));

  ejector_host_model ejector_host_model_i (.sys_clk(sys_clk), .reset(reset), .want_pins(want_pins),
    .want_fb(want_fb), .want_opb(want_opb), .pins_async(pins_async), .fb_mode_set(fb_mode_set),
    .fb_mode_clr(fb_mode_clr), .output_process_byte(output_process_byte), .opb_valid(opb_valid));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [7:0] obs();
    return {1'b0, led_limit2, led_limit1, op_mode, direct_wire_mode, blow_valve, vacuum_gen};
  endfunction

  task automatic close_out;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request held until waitrequest is seen low at an edge; only then released
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] q);
    @(posedge sys_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= wd;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  task automatic wr_rd(input logic [3:0] a, input logic [31:0] wd, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b1, a, wd, q);
    rd_chk(a, e);
  endtask

  task automatic wait_obs(input logic [7:0] m, input logic [7:0] v, input int lim, output int k);
    k = 0;
    while ((obs() & m) !== v && k < lim) begin
      @(posedge sys_clk);
      k++;
    end
    chk({24'h0, obs() & m}, {24'h0, v});
  endtask

  // Blow length may lose up to one 10 ms step to tick alignment
  task automatic blow_len(input int dur);
    int k;
    for (k = 0; k < 3000 && blow_valve === 1'b1; k++) @(posedge sys_clk);
    chk({31'h0, k >= (dur * 10 - 11) * MS && k <= (dur * 10 + 2) * MS}, 32'h1);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      close_out;
    end
  end

  initial begin
    reset = 1'b1;
    {avs_read, avs_write, want_fb, leak_valid} = 4'h0;
    avs_address = 4'h0;
    avs_byteenable = 4'hf;
    avs_writedata = 32'h0;
    want_pins = '0;
    {want_opb, vacuum_level, leak_rate} = 24'h0;
    seed = 16'h0ace;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    wait_obs(8'h1f, 8'h04, 2, n);
    rd_chk(OFS_CTRL, 32'h10);
    rd_chk(OFS_DUR, 32'h0);
    rd_chk(OFS_LIM, 32'h64200a96);
    wr_rd(OFS_CTRL, 32'h16, 32'h12);
    wr_rd(OFS_CTRL, 32'h48, 32'h08);
    wr_rd(OFS_CTRL, 32'h58, 32'h58);
    wr_rd(OFS_CTRL, 32'h18, 32'h18);
    wr_rd(OFS_DUR, 32'h5, 32'h00a);
    wr_rd(OFS_DUR, 32'h3ff, 32'h3e7);
    for (i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      d = 32'(seed % 16'd990) + 32'd10;
      wr_rd(OFS_DUR, d, d);
    end
    wr_rd(OFS_DUR, 32'h00a, 32'h00a);
    want_pins.blow <= 1'b1;
    wait_obs(8'h02, 8'h02, 20, n);
    blow_len(10);
    repeat (100) @(posedge sys_clk);
    chk({24'h0, obs() & 8'h02}, 32'h0);
    want_pins.blow <= 1'b0;
    want_pins.suction <= 1'b1;
    vacuum_level <= 8'h10;
    wait_obs(8'h03, 8'h01, 20, n);
    vacuum_level <= RST_CL;
    wait_obs(8'h03, 8'h00, 20, n);
    vacuum_level <= RST_CL - RST_HY;
    repeat (10) @(posedge sys_clk);
    chk({24'h0, obs() & 8'h03}, 32'h0);
    vacuum_level <= RST_CL - RST_HY - 8'h01;
    wait_obs(8'h03, 8'h01, 20, n);
    wr_rd(OFS_CTRL, 32'h10, 32'h10);
    want_pins.blow <= 1'b1;
    wait_obs(8'h03, 8'h02, 20, n);
    repeat (600) @(posedge sys_clk);
    chk({24'h0, obs() & 8'h03}, 32'h2);
    want_pins.blow <= 1'b0;
    wait_obs(8'h03, 8'h01, 20, n);
    wr_rd(OFS_CTRL, 32'h14, 32'h14);
    wr_rd(OFS_DUR, 32'h00a, 32'h00a);
    want_pins.suction <= 1'b0;
    wait_obs(8'h03, 8'h02, 20, n);
    blow_len(10);
    want_fb <= 1'b1;
    wait_obs(8'h04, 8'h00, 20, n);
    want_opb <= 8'h04;
    wait_obs(8'h18, 8'h10, 40, n);
    want_opb <= 8'h05;
    wait_obs(8'h18, 8'h00, 40, n);
    want_opb <= 8'h00;
    want_fb <= 1'b0;
    wait_obs(8'h04, 8'h04, 40, n);
    vacuum_level <= 8'h10;
    want_pins.up <= 1'b1;
    want_pins.down <= 1'b1;
    wait_obs(8'h18, 8'h08, 3200 * MS, n);
    chk({31'h0, n >= 2999 * MS}, 32'h1);
    want_pins.up <= 1'b0;
    want_pins.down <= 1'b0;
    repeat (10) @(posedge sys_clk);
    want_pins.up <= 1'b1;
    repeat (10) @(posedge sys_clk);
    want_pins.up <= 1'b0;
    wait_obs(8'h1b, 8'h09, 30, n);
    want_pins.down <= 1'b1;
    wait_obs(8'h7b, 8'h6a, 30, n);
    want_pins.down <= 1'b0;
    wait_obs(8'h1b, 8'h08, 30, n);
    want_pins.menu <= 1'b1;
    wait_obs(8'h18, 8'h00, 30, n);
    want_pins.menu <= 1'b0;
    wr_rd(OFS_CTRL, 32'h24, 32'h24);
    want_pins.suction <= 1'b1;
    vacuum_level <= RST_CL;
    leak_rate <= 8'h30;
    repeat (20) @(posedge sys_clk);
    leak_valid <= 1'b1;
    repeat (2) @(posedge sys_clk);
    leak_valid <= 1'b0;
    repeat (5) @(posedge sys_clk);
    chk({24'h0, obs() & 8'h63}, 32'h60);
    leak_valid <= 1'b1;
    @(posedge sys_clk);
    leak_valid <= 1'b0;
    wait_obs(8'h03, 8'h01, 10, n);
    wr_rd(OFS_CTRL, 32'h64, 32'h64);
    want_pins.suction <= 1'b0;
    repeat (20) @(posedge sys_clk);
    want_pins.suction <= 1'b1;
    repeat (600) @(posedge sys_clk);
    chk({24'h0, obs() & 8'h03}, 32'h0);
    want_pins.undervolt <= 1'b1;
    wr_rd(OFS_CTRL, 32'h65, 32'h65);
    wait_obs(8'h03, 8'h01, 20, n);
    want_pins.undervolt <= 1'b0;
    want_pins.suction <= 1'b0;
    vacuum_level <= 8'h10;
    repeat (20) @(posedge sys_clk);
    wait_obs(8'h03, 8'h01, 600, n);
    wr_rd(OFS_CTRL, 32'h62, 32'h62);
    wr_rd(OFS_CTRL, 32'h42, 32'h62);
    want_pins.suction <= 1'b1;
    wait_obs(8'h03, 8'h01, 20, n);
    want_pins.blow <= 1'b1;
    wait_obs(8'h03, 8'h02, 20, n);
    want_pins.blow <= 1'b0;
    repeat (20) @(posedge sys_clk);
    chk({24'h0, obs() & 8'h03}, 32'h0);
    want_pins.suction <= 1'b0;
    repeat (10) @(posedge sys_clk);
    want_pins.suction <= 1'b1;
    wait_obs(8'h03, 8'h01, 20, n);
    rd_chk(OFS_STAT, 32'h00100010);
    close_out;
  end
endmodule
